// File: rtl/ishi_host_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "ishi_consts.svh"

module ishi_host_if (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       sel_serial,
  input  wire logic       serial_mode_sel0,
  input  wire logic       serial_mode_sel1,
  input  wire logic       cs_n,
  input  wire logic       ale_rst,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic       sync_strobe,
  input  wire logic       output_disable_n,
  input  wire logic [7:0] addr_data_bus_i,
  output logic [7:0]      addr_data_bus_o,
  output logic [7:0]      addr_data_bus_oe,
  input  wire logic       uv_fault,
  input  wire logic       tx_fault,
  input  wire logic [7:0] chan_fault,
  input  wire logic [7:0] chan_channel_register_a,
  input  wire logic       channel_register_a_valid,
  output logic [7:0]      switch_outputs,
  output logic            fault_n_o,
  output logic            fault_n_oe,
  output logic            serial_active,
  output logic            direct_active
);
  import ishi_pkg::*;

  localparam int PIN_RST_LAST = `ISHI_PIN_RST_CYC - 1;

  logic         sel_b, ms0_b, ms1_b, cs_b, ale_b, wr_b, rd_b, sync_b, output_disable_n_b;
  logic [7:0]   bus_b;
  logic         pin_rst_q, core_rst, cs_q, sclk_q;
  logic [11:0]  rst_cnt_q;
  ishi_pstate_e pst_q;
  logic [7:0]   addr_q, drive_q, cfg_q, channel_register_a_q, rd_data;
  logic [5:0]   dir_cnt_q;
  ishi_smode_e  mode_q;
  logic [23:0]  rx_q, tx_q;
  logic [4:0]   bit_cnt_q, crc_val, need_len, crc_len;
  logic         sdo_q, crc_err_q, ser_en, sclk_rise, sclk_fall;
  logic         cs_fall, cs_rise, frame_end, frame_bad;
  logic         wr_en, par_wr, fault_any;
  logic [6:0]   wr_idx;
  logic [7:0]   wr_data, ser_addr, ser_data;

  default clocking dclk @(posedge ref_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  // Input conditioning; mode selects use the long window
  ishi_blank #(.CYC(`ISHI_BLANK_SLOW_CYC), .RST_VAL(1'b0)) u_sel (
    .ref_clk(ref_clk), .rst(rst), .pin(sel_serial), .level(sel_b));
  ishi_blank #(.CYC(`ISHI_BLANK_SLOW_CYC), .RST_VAL(1'b0)) u_ms0 (
    .ref_clk(ref_clk), .rst(rst), .pin(serial_mode_sel0), .level(ms0_b));
  ishi_blank #(.CYC(`ISHI_BLANK_SLOW_CYC), .RST_VAL(1'b0)) u_ms1 (
    .ref_clk(ref_clk), .rst(rst), .pin(serial_mode_sel1), .level(ms1_b));
  ishi_blank #(.CYC(`ISHI_BLANK_FAST_CYC), .RST_VAL(1'b1)) u_cs (
    .ref_clk(ref_clk), .rst(rst), .pin(cs_n), .level(cs_b));
  ishi_blank #(.CYC(`ISHI_BLANK_FAST_CYC), .RST_VAL(1'b0)) u_ale (
    .ref_clk(ref_clk), .rst(rst), .pin(ale_rst), .level(ale_b));
  ishi_blank #(.CYC(`ISHI_BLANK_FAST_CYC), .RST_VAL(1'b1)) u_wr (
    .ref_clk(ref_clk), .rst(rst), .pin(wr_n), .level(wr_b));
  ishi_blank #(.CYC(`ISHI_BLANK_FAST_CYC), .RST_VAL(1'b1)) u_rd (
    .ref_clk(ref_clk), .rst(rst), .pin(rd_n), .level(rd_b));
  ishi_blank #(.CYC(`ISHI_BLANK_FAST_CYC), .RST_VAL(1'b1)) u_sync (
    .ref_clk(ref_clk), .rst(rst), .pin(sync_strobe), .level(sync_b));
  // Disable starts asserted so outputs stay off until the pin is seen
  ishi_blank #(.CYC(`ISHI_BLANK_FAST_CYC), .RST_VAL(1'b0)) u_output_disable_n (
    .ref_clk(ref_clk), .rst(rst), .pin(output_disable_n), .level(output_disable_n_b));

  for (genvar i = 0; i < 8; i++) begin : g_bus
    ishi_blank #(.CYC(`ISHI_BLANK_FAST_CYC), .RST_VAL(1'b0)) u_ad (
      .ref_clk(ref_clk), .rst(rst), .pin(addr_data_bus_i[i]),
      .level(bus_b[i]));
  end

  ////////////////////////////////////////////////////////////////////////
  // held select and latch strobe reset
  // Counter itself only obeys the external reset, else it would kill itself
  always_ff @(posedge ref_clk) begin
    if (rst || cs_b || !ale_b) begin
      rst_cnt_q <= 12'h000;
      pin_rst_q <= 1'b0;
    end else if (rst_cnt_q == 12'(PIN_RST_LAST)) begin
      pin_rst_q <= 1'b1;
    end else begin
      rst_cnt_q <= rst_cnt_q + 12'h001;
    end
  end
  assign core_rst = rst || pin_rst_q;

  pin_reset_a: assert property (
    $rose(pin_rst_q) |-> ($past(rst_cnt_q) == 12'(PIN_RST_LAST)) && !cs_b)
    else $error("pin reset fired without full hold time");

  ////////////////////////////////////////////////////////////////////////
  // interface select, parallel after reset
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      serial_active <= 1'b0;
    end else begin
      serial_active <= sel_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Parallel access sequencer
  always_ff @(posedge ref_clk) begin
    if (core_rst || serial_active) begin
      pst_q <= ISHI_P_IDLE;
    end else begin
      case (pst_q)
        ISHI_P_IDLE: begin
          if (!cs_b && ale_b) begin
            pst_q <= ISHI_P_ADDR;
          end else if (!cs_b && !wr_b && rd_b) begin
            pst_q <= ISHI_P_WRITE;
          end else if (!cs_b && !rd_b && wr_b) begin
            pst_q <= ISHI_P_READ;
          end
        end
        ISHI_P_ADDR: begin
          if (cs_b || !ale_b) begin
            pst_q <= ISHI_P_IDLE;
          end
        end
        ISHI_P_WRITE: begin
          // strobes held tied enter direct mode
          if (cs_b || wr_b) begin
            pst_q <= ISHI_P_IDLE;
          end else if (dir_cnt_q == 6'(`ISHI_DIRECT_CYC - 1) && rd_b &&
                       !ale_b) begin
            pst_q <= ISHI_P_DIRECT;
          end
        end
        ISHI_P_READ: begin
          if (cs_b || rd_b) begin
            pst_q <= ISHI_P_IDLE;
          end
        end
        ISHI_P_DIRECT: begin
          if (cs_b || wr_b || ale_b || !rd_b) begin
            pst_q <= ISHI_P_IDLE;
          end
        end
        default: pst_q <= ISHI_P_IDLE;
      endcase
    end
  end

  // Hold counter for the direct mode test
  always_ff @(posedge ref_clk) begin
    if (core_rst || pst_q != ISHI_P_WRITE) begin
      dir_cnt_q <= 6'h00;
    end else if (dir_cnt_q != 6'(`ISHI_DIRECT_CYC - 1)) begin
      dir_cnt_q <= dir_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      addr_q <= `ISHI_ADDR_RST;
    end else if (pst_q == ISHI_P_ADDR && ale_b && !cs_b) begin
      addr_q <= bus_b;
    end
  end

  addr_latch_a: assert property (
    (pst_q == ISHI_P_ADDR && ale_b && !cs_b && !pin_rst_q) |=>
    addr_q == $past(bus_b))
    else $error("address not latched from bus");

  addr_keep_a: assert property (
    (!ale_b && !pin_rst_q) |=> $stable(addr_q))
    else $error("address changed while latch strobe low");

  // write taken at strobe rise, bit7 set
  assign par_wr = (pst_q == ISHI_P_WRITE) && wr_b && !cs_b && !ale_b &&
                  addr_q[`ISHI_ADDR_WR_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Serial engine, shift clock edges found by sampling
  assign ser_en    = serial_active && !cs_b;
  assign sclk_rise = ser_en && bus_b[`ISHI_SCLK_BIT] && !sclk_q;
  assign sclk_fall = ser_en && !bus_b[`ISHI_SCLK_BIT] && sclk_q;
  assign cs_fall   = serial_active && !cs_b && cs_q;
  assign cs_rise   = serial_active && cs_b && !cs_q;

  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      cs_q   <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      cs_q   <= cs_b;
      sclk_q <= bus_b[`ISHI_SCLK_BIT];
    end
  end

  // frame length and check sum span
  always_comb begin
    need_len = `ISHI_FRAME_LEN_M0;
    crc_len  = 5'd0;
    case (mode_q)
      ISHI_SM0: need_len = `ISHI_FRAME_LEN_M0;
      ISHI_SM1: begin
        need_len = `ISHI_FRAME_LEN_M1;
        crc_len  = `ISHI_CRC_BITS_M1;
      end
      ISHI_SM2: need_len = `ISHI_FRAME_LEN_M2;
      ISHI_SM3: begin
        need_len = `ISHI_FRAME_LEN_M3;
        crc_len  = `ISHI_CRC_BITS_M3;
      end
      default: need_len = `ISHI_FRAME_LEN_M0;
    endcase
  end

  // sample on rise, shift out on fall
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      mode_q    <= ISHI_SM0;
      rx_q      <= 24'h000000;
      tx_q      <= 24'h000000;
      bit_cnt_q <= 5'd0;
      sdo_q     <= 1'b0;
    end else if (cs_fall) begin
      mode_q    <= ishi_smode_e'({ms1_b, ms0_b});
      rx_q      <= 24'h000000;
      tx_q      <= {channel_register_a_q[6:0], rd_data, 8'h00, 1'b0};
      bit_cnt_q <= 5'd0;
      sdo_q     <= channel_register_a_q[7];
    end else begin
      if (sclk_rise) begin
        rx_q <= {rx_q[22:0], bus_b[`ISHI_SDI_BIT]};
        // Saturate so an overlong frame still counts as wrong
        if (bit_cnt_q != 5'h1F) begin
          bit_cnt_q <= bit_cnt_q + 5'd1;
        end
      end
      if (sclk_fall) begin
        sdo_q <= tx_q[23];
        tx_q  <= {tx_q[22:0], 1'b0};
      end
    end
  end

  ishi_crc5 u_crc (
    .ref_clk(ref_clk),
    .rst    (core_rst),
    .clr    (cs_fall),
    .en     (sclk_rise && bit_cnt_q < crc_len),
    .din    (bus_b[`ISHI_SDI_BIT]),
    .crc    (crc_val)
  );

  assign frame_end = cs_rise;
  assign frame_bad = (bit_cnt_q != need_len) ||
                     (crc_len != 5'd0 && crc_val != rx_q[4:0]);

  // Flag lasts until the next frame starts
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      crc_err_q <= 1'b0;
    end else if (frame_end && frame_bad) begin
      crc_err_q <= 1'b1;
    end else if (cs_fall) begin
      crc_err_q <= 1'b0;
    end
  end

  crc_flag_a: assert property (
    (frame_end && frame_bad && !pin_rst_q) |=> ##1
    addr_data_bus_oe[`ISHI_CRC_FAULT_N_BIT] && !addr_data_bus_o[`ISHI_CRC_FAULT_N_BIT])
    else $error("frame error did not pull error flag");

  // frame fields to address and data
  always_comb begin
    ser_addr = {1'b1, `ISHI_REG_DRIVE};
    ser_data = rx_q[7:0];
    case (mode_q)
      ISHI_SM0: ser_data = rx_q[7:0];
      ISHI_SM1: ser_data = rx_q[15:8];
      ISHI_SM2: begin
        ser_addr = rx_q[15:8];
        ser_data = rx_q[7:0];
      end
      ISHI_SM3: begin
        ser_addr = rx_q[23:16];
        ser_data = rx_q[15:8];
      end
      default: ser_data = rx_q[7:0];
    endcase
  end

  // One write port shared by both interfaces
  always_comb begin
    wr_en   = 1'b0;
    wr_idx  = 7'h00;
    wr_data = 8'h00;
    if (par_wr) begin
      wr_en   = 1'b1;
      wr_idx  = addr_q[6:0];
      wr_data = bus_b;
    end else if (frame_end && !frame_bad &&
                 ser_addr[`ISHI_ADDR_WR_BIT]) begin
      wr_en   = 1'b1;
      wr_idx  = ser_addr[6:0];
      wr_data = ser_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // disable clears the drive register
  always_ff @(posedge ref_clk) begin
    if (core_rst || !output_disable_n_b) begin
      drive_q <= 8'h00;
    end else if (pst_q == ISHI_P_DIRECT) begin
      drive_q <= bus_b;
    end else if (wr_en && wr_idx == `ISHI_REG_DRIVE) begin
      drive_q <= wr_data;
    end
  end

  // Configuration register
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      cfg_q <= `ISHI_CFG_RST;
    end else if (wr_en && wr_idx == `ISHI_REG_CFG) begin
      cfg_q <= wr_data;
    end
  end

  write_cap_a: assert property (
    (par_wr && addr_q[6:0] == `ISHI_REG_CFG && !pin_rst_q) |=>
    cfg_q == $past(bus_b))
    else $error("parallel write not captured");

  always_ff @(posedge ref_clk) begin
    if (core_rst || !output_disable_n_b) begin
      switch_outputs <= 8'h00;
    end else if (!cfg_q[`ISHI_CFG_ISO_BIT] || sync_b) begin
      switch_outputs <= drive_q;
    end
  end

  output_disable_n_clear_a: assert property (
    !output_disable_n_b |=> (drive_q == 8'h00) && (switch_outputs == 8'h00))
    else $error("disable did not clear drive and outputs");

  iso_freeze_a: assert property (
    (cfg_q[`ISHI_CFG_ISO_BIT] && !sync_b && output_disable_n_b && !pin_rst_q) |=>
    $stable(switch_outputs))
    else $error("outputs moved while sync low");

  sync_xfer_a: assert property (
    ($rose(sync_b) && output_disable_n_b && !pin_rst_q) |=>
    switch_outputs == $past(drive_q))
    else $error("sync rise did not transfer drive");

  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      channel_register_a_q <= 8'h00;
    end else if (channel_register_a_valid && (!cfg_q[`ISHI_CFG_DSYNC_BIT] || sync_b)) begin
      channel_register_a_q <= chan_channel_register_a;
    end
  end

  channel_register_a_hold_a: assert property (
    (cfg_q[`ISHI_CFG_DSYNC_BIT] && !sync_b && !pin_rst_q) |=> $stable(channel_register_a_q))
    else $error("diagnostics updated while sync low");

  // read data for the latched address
  always_comb begin
    case (addr_q[6:0])
      `ISHI_REG_DRIVE: rd_data = drive_q;
      `ISHI_REG_CHANNEL_REGISTER_A:  rd_data = channel_register_a_q;
      `ISHI_REG_CFG:   rd_data = cfg_q;
      `ISHI_REG_STAT:  rd_data = {4'h0, crc_err_q, uv_fault, tx_fault,
                                  |chan_fault};
      default:         rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers, all registered
  // fault pin is the OR of uv_fault, tx_fault and all chan_fault bits, not of the frame error flag
  assign fault_any = uv_fault || tx_fault || (|chan_fault);

  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      fault_n_oe <= 1'b0;
    end else begin
      fault_n_oe <= fault_any;
    end
  end

  fault_or_a: assert property (
    !pin_rst_q |=> fault_n_oe == $past(fault_any))
    else $error("fault pin does not follow fault sources");

  // Open-drain pins only ever drive low
  always_ff @(posedge ref_clk) begin
    fault_n_o <= 1'b0;
  end

  // drive read data while strobe low
  // serial data out only with chip select
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      addr_data_bus_o  <= 8'h00;
      addr_data_bus_oe <= 8'h00;
      direct_active    <= 1'b0;
    end else begin
      addr_data_bus_o  <= 8'h00;
      addr_data_bus_oe <= 8'h00;
      direct_active    <= (pst_q == ISHI_P_DIRECT);
      if (serial_active) begin
        addr_data_bus_o[`ISHI_SDO_BIT]     <= sdo_q;
        addr_data_bus_oe[`ISHI_SDO_BIT]    <= !cs_b;
        addr_data_bus_oe[`ISHI_CRC_FAULT_N_BIT] <= crc_err_q;
      end else if (pst_q == ISHI_P_READ && !cs_b && !rd_b) begin
        addr_data_bus_o  <= rd_data;
        addr_data_bus_oe <= 8'hFF;
      end
    end
  end

  cs_gate_a: assert property (
    (cs_b && !serial_active) |=> addr_data_bus_oe == 8'h00)
    else $error("parallel bus driven without chip select");

  sdo_release_a: assert property (
    (cs_b && serial_active) |=> !addr_data_bus_oe[`ISHI_SDO_BIT])
    else $error("serial data out driven without chip select");

endmodule // ishi_host_if

`default_nettype wire

// File: inc/ishi_consts.svh
`ifndef ISHI_CONSTS_SVH
`define ISHI_CONSTS_SVH

////////////////////////////////////////////////////////////////////////
// Clock and blanking times
`define ISHI_CLK_PERIOD_NS   25
`define ISHI_BLANK_FAST_NS   20
`define ISHI_BLANK_SLOW_NS   200
`define ISHI_BLANK_FAST_CYC \
  ((`ISHI_BLANK_FAST_NS + `ISHI_CLK_PERIOD_NS - 1) / `ISHI_CLK_PERIOD_NS)
`define ISHI_BLANK_SLOW_CYC \
  ((`ISHI_BLANK_SLOW_NS + `ISHI_CLK_PERIOD_NS - 1) / `ISHI_CLK_PERIOD_NS)

// Reset by held chip select and latch strobe
`define ISHI_PIN_RST_US      100
`define ISHI_PIN_RST_CYC \
  ((`ISHI_PIN_RST_US * 1000 + `ISHI_CLK_PERIOD_NS - 1) / `ISHI_CLK_PERIOD_NS)

// Least low time of the output disable, kept by the host
`define ISHI_OUTPUT_DISABLE_N_MIN_US     5

// Hold time that tells a tied direct mode from a write strobe
`define ISHI_DIRECT_NS       1000
`define ISHI_DIRECT_CYC \
  ((`ISHI_DIRECT_NS + `ISHI_CLK_PERIOD_NS - 1) / `ISHI_CLK_PERIOD_NS)

////////////////////////////////////////////////////////////////////////
// Serial frames and check sum
`define ISHI_FRAME_LEN_M0    5'd8
`define ISHI_FRAME_LEN_M1    5'd16
`define ISHI_FRAME_LEN_M2    5'd16
`define ISHI_FRAME_LEN_M3    5'd24
`define ISHI_CRC_BITS_M1     5'd11
`define ISHI_CRC_BITS_M3     5'd19
`define ISHI_CRC_INIT        5'h1F
`define ISHI_CRC_POLY        5'h15

////////////////////////////////////////////////////////////////////////
// Internal register indices, fields and reset values
`define ISHI_REG_DRIVE       7'h00
`define ISHI_REG_CHANNEL_REGISTER_A        7'h01
`define ISHI_REG_CFG         7'h02
`define ISHI_REG_STAT        7'h03
`define ISHI_CFG_ISO_BIT     0
`define ISHI_CFG_DSYNC_BIT   1
`define ISHI_CFG_RST         8'h00
`define ISHI_ADDR_WR_BIT     7
`define ISHI_ADDR_RST        8'h80

// Shared bus lanes in serial mode
`define ISHI_SDI_BIT         0
`define ISHI_CRC_FAULT_N_BIT      4
`define ISHI_SCLK_BIT        5
`define ISHI_SDO_BIT         7

`endif

// File: inc/ishi_pkg.sv
`include "ishi_consts.svh"

package ishi_pkg;

  typedef enum logic [2:0] {
    ISHI_P_IDLE, ISHI_P_ADDR, ISHI_P_WRITE, ISHI_P_READ, ISHI_P_DIRECT
  } ishi_pstate_e;

  typedef enum logic [1:0] {
    ISHI_SM0, ISHI_SM1, ISHI_SM2, ISHI_SM3
  } ishi_smode_e;

  // One serial step of the 5-bit check sum
  function automatic logic [4:0] ishi_crc_step(input logic [4:0] crc,
                                               input logic       din);
    logic fb;
    fb = crc[4] ^ din;
    return {crc[3:0], 1'b0} ^ (fb ? `ISHI_CRC_POLY : 5'h00);
  endfunction

endpackage

// File: rtl/ishi_blank.sv
`timescale 1ns/10ps
`default_nettype none
`include "ishi_consts.svh"

module ishi_blank #(
  parameter int unsigned CYC     = 1,
  parameter logic        RST_VAL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  logic       meta_q;
  logic       sync_q;
  logic [7:0] cnt_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  // blanking qualification
  // A glitch shorter than the window restarts the count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level <= RST_VAL;
      cnt_q <= 8'h00;
    end else if (sync_q == level) begin
      cnt_q <= 8'h00;
    end else if (cnt_q >= 8'(CYC - 1)) begin
      level <= sync_q;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  blank_accept_a: assert property (@(posedge ref_clk) disable iff (rst)
    (level != $past(level)) |-> ($past(sync_q) == level))
    else $error("blanked level took a value not held");

endmodule // ishi_blank

`default_nettype wire

// File: rtl/ishi_crc5.sv
`timescale 1ns/10ps
`default_nettype none
`include "ishi_consts.svh"

module ishi_crc5 (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic       din,
  output logic [4:0]      crc
);
  import ishi_pkg::*;

  // check sum register, preset per frame
  always_ff @(posedge ref_clk) begin
    if (rst || clr) begin
      crc <= `ISHI_CRC_INIT;
    end else if (en) begin
      crc <= ishi_crc_step(crc, din);
    end
  end

endmodule // ishi_crc5

`default_nettype wire

// File: sim/ishi_spi_host.sv
`timescale 1ns/10ps
`default_nettype none

// Serial host on the far side; its clock stands still between frames
module ishi_spi_host (
  input  wire logic ref_clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  //////////////////////////////////////////////////////////////////
  // framed shift, MSB first
  // Data moves on the low phase so it is settled at each clock rise
  task automatic frame(input logic [23:0] w, input int n);
    @(posedge ref_clk) cs_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int i = n - 1; i >= 0; i--) begin
      sdi <= w[i];
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge ref_clk);
    cs_n <= 1'b1;
    sdi  <= 1'b0; // Released line falls to its pull-down
    repeat (16) @(posedge ref_clk);
  endtask
endmodule // ishi_spi_host

`default_nettype wire

// File: sim/ishi_host_if_test.sv
`timescale 1ns/10ps
`default_nettype none

module ishi_host_if_test;
  logic        ref_clk, rst, sel, ms0, ms1, cs_n, ale, wr_n, rd_n, bad;
  logic        sync, output_disable_n_n, uv, tx, dv, fo, foe, sa, da, hcs, sclk, sdi;
  logic [7:0]  bus, cf, cd, bo, boe, sw, bw, drv, dg, rv, d;
  logic [23:0] w;
  int          fails, tests_run, seed;
  int          md[6] = '{0, 0, 1, 1, 2, 3};
  int          nb[6] = '{8, 7, 16, 16, 16, 24};

  // Pin level: device wins where enabled, error lane pulled up
  assign bw = (boe & bo) |
              (~boe & (sel ? {2'h0, sclk, 1'h1, 3'h0, sdi} : bus));

  ishi_host_if DUT (
    .ref_clk (ref_clk), .rst (rst),
    .sel_serial (sel), .serial_mode_sel0 (ms0), .serial_mode_sel1 (ms1),
    .cs_n (sel ? hcs : cs_n), .ale_rst (ale), .wr_n (wr_n), .rd_n (rd_n),
    .sync_strobe (sync), .output_disable_n (output_disable_n_n),
    .addr_data_bus_i (bw), .addr_data_bus_o (bo), .addr_data_bus_oe (boe),
    .uv_fault (uv), .tx_fault (tx), .chan_fault (cf),
    .chan_channel_register_a (cd), .channel_register_a_valid (dv), .switch_outputs (sw),
    .fault_n_o (fo), .fault_n_oe (foe),
    .serial_active (sa), .direct_active (da)
  );
  ishi_spi_host u_host (.ref_clk(ref_clk), .cs_n(hcs), .sclk(sclk),
                        .sdi(sdi));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reference check sum, init all ones, taps 0x15
  function automatic logic [4:0] crc5(input logic [23:0] v, input int n);
    logic [4:0] c;
    c = 5'h1F;
    for (int i = n - 1; i >= 5; i--)
      c = {c[3:0], 1'b0} ^ ((c[4] ^ v[i]) ? 5'h15 : 5'h00);
    return c;
  endfunction
  // address phase with both strobes high
  task automatic addr(input logic [7:0] a);
    cs_n <= 1'b0;
    ale  <= 1'b1;
    bus  <= a;
    tick(8);
    ale  <= 1'b0;
    tick(2);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    addr(a);
    bus  <= v;
    tick(6);
    wr_n <= 1'b0;
    tick(6);
    wr_n <= 1'b1;
    tick(6); // Data held past the strobe rise
    cs_n <= 1'b1;
    tick(4);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    addr(a);
    rd_n <= 1'b0;
    tick(10);
    @(negedge ref_clk);
    v = bo;
    check(boe, 8'hFF);
    tick(1);
    rd_n <= 1'b1;
    tick(8);
    cs_n <= 1'b1;
    tick(4);
  endtask
  task automatic pulse;
    cd <= 8'($random(seed));
    dv <= 1'b1;
    tick(1);
    dv <= 1'b0;
    tick(1);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog: the run needs about 6000 cycles
  initial begin
    tick(30000);
    fails++;
    results();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h04af;
    fails = 0;
    tests_run = 0;
    {rst, sel, ms0, ms1, ale, dv, uv, tx} = 8'h80;
    {cs_n, wr_n, rd_n, sync, output_disable_n_n} = 5'h1F;
    {bus, cf, cd, drv, dg} = 40'h0;
    tick(3);
    rst <= 1'b0;
    tick(10);
    @(negedge ref_clk);
    check(sw, 8'h00);
    check({fo, foe, sa, da, 4'h0}, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      drv = 8'($random(seed));
      wr(8'h80, drv);
      @(negedge ref_clk);
      check(sw, drv);
      tick(1);
    end
    wr(8'h00, ~drv);
    rd(8'h00, rv);
    check(rv, drv);
    check(boe, 8'h00);
    $display("test parallel done");
    // Diagnostics follow the strobe only once frozen mode is set
    pulse();
    dg = cd;
    rd(8'h01, rv);
    check(rv, dg);
    wr(8'h82, 8'h03);
    sync <= 1'b0;
    rv = drv;
    drv = 8'($random(seed));
    wr(8'h80, drv);
    pulse();
    @(negedge ref_clk);
    check(sw, rv);
    rd(8'h01, rv);
    check(rv, dg);
    sync <= 1'b1;
    tick(6);
    @(negedge ref_clk);
    check(sw, drv);
    tick(1);
    wr(8'h82, 8'h00);
    $display("test sync done");
    for (int i = 0; i <= 10; i++) begin
      {uv, tx, cf} <= 10'h1 << i;
      tick(6);
      @(negedge ref_clk);
      check({7'h0, foe}, {7'h0, i < 10});
      tick(1);
    end
    output_disable_n_n <= 1'b0;
    tick(200);
    output_disable_n_n <= 1'b1;
    tick(6);
    drv = 8'h00;
    rd(8'h00, rv);
    check(rv, drv);
    check(sw, drv);
    $display("test fault and disable done");
    drv = 8'($random(seed)) | 8'h01;
    wr(8'h80, drv);
    cs_n <= 1'b0;
    ale  <= 1'b1;
    tick(4100);
    cs_n <= 1'b1;
    ale  <= 1'b0;
    tick(10);
    drv = 8'h00;
    @(negedge ref_clk);
    check(sw, drv);
    tick(1);
    // Tied strobes: outputs track the bus
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      drv = 8'($random(seed));
      bus <= drv;
      tick(60);
      @(negedge ref_clk);
      check(sw, drv);
      check({7'h0, da}, 8'h01);
      tick(1);
    end
    wr_n <= 1'b1;
    cs_n <= 1'b1;
    $display("test pin reset and direct done");
    pulse();
    dg = cd;
    sel <= 1'b1;
    tick(20);
    @(negedge ref_clk);
    check({7'h0, sa}, 8'h01);
    for (int k = 0; k < 6; k++) begin
      d = 8'($random(seed));
      bad = (k == 1 || k == 3);
      {ms1, ms0} <= 2'(md[k]);
      w = (k < 2) ? {16'h0, d} : (k == 4) ? {8'h0, 8'h80, d} :
          (k == 5) ? {8'h80, d, 8'h0} : {8'h0, d, 8'h0};
      if (k == 2 || k == 3 || k == 5)
        w[4:0] = crc5(w, nb[k]) ^ {4'h0, k == 3};
      tick(12);
      fork
        u_host.frame(w, nb[k]);
        begin
          // First serial data out bit is the top diagnostic bit
          tick(12);
          @(negedge ref_clk);
          check({6'h0, boe[7], bo[7]}, {6'h0, 1'b1, dg[7]});
        end
      join
      if (!bad)
        drv = d;
      @(negedge ref_clk);
      check(sw, drv);
      check({7'h0, bw[4]}, {7'h0, !bad});
      check({7'h0, boe[7]}, 8'h00);
      tick(1);
    end
    $display("test serial done");
    results();
  end
endmodule // ishi_host_if_test

`default_nettype wire
